//--- core/hbpi_consts.svh
// constants of the host bus pin interface
`ifndef HBPI_CONSTS_SVH
`define HBPI_CONSTS_SVH
`define HBPI_DATA_W      8
`define HBPI_SEP_W       7
`define HBPI_SCLK_BIT    5
`define HBPI_RX_BIT      6
`define HBPI_TX_BIT      7
`define HBPI_IND_SEL_BIT 0
`define HBPI_BYTE_LAST   4'h7
`define HBPI_CNT_RST     4'h0
`define HBPI_BYTE_RST    8'h00
`define HBPI_OE_OFF      8'hFF
`define HBPI_OE_ON       8'h00
`define HBPI_SER_OE_LOW  7'h7F
`define HBPI_SER_OUT_LOW 7'h00
`endif

//--- core/hbpi_pkg.sv
// types of the host bus pin interface
package hbpi_pkg;
	typedef enum logic [1:0] {
		MODE_STROBES = 2'b00,
		MODE_DSTROBE = 2'b01,
		MODE_SERIAL  = 2'b10
	} hbpi_mode_e;
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_HDR  = 2'b01,
		SER_DATA = 2'b10
	} hbpi_ser_e;
endpackage

//--- core/hbpi_ser_if.sv
// carrier between the top and the serial control port engine
`timescale 1ns/1ps
`include "hbpi_consts.svh"
interface hbpi_ser_if;
	logic                   cs_n;
	logic                   sclk;
	logic                   sdi;
	logic                   od_mode;
	logic                   serial_port_tx;
	logic                   serial_port_tx_oe_n;
	logic                   rd_req;
	logic                   wr_req;
	logic [`HBPI_DATA_W-1:0] addr;
	logic [`HBPI_DATA_W-1:0] wdata;
	logic [`HBPI_DATA_W-1:0] rdata;
	modport engine (input cs_n, sclk, sdi, od_mode, rdata,
		output serial_port_tx, serial_port_tx_oe_n, rd_req, wr_req, addr, wdata);
	modport host (output cs_n, sclk, sdi, od_mode, rdata,
		input serial_port_tx, serial_port_tx_oe_n, rd_req, wr_req, addr, wdata);
endinterface

//--- core/hbpi_serial.sv
// serial control port engine: header byte then one data byte
`timescale 1ns/1ps
`include "hbpi_consts.svh"
module hbpi_serial import hbpi_pkg::*; (
	input  wire logic   clk,   // system clock
	input  wire logic   rst,   // async reset, high
	hbpi_ser_if.engine  sif    // pins and register requests
);
	hbpi_ser_e               st_q, st_d;
	logic [3:0]              cnt_q, cnt_d;
	logic [`HBPI_DATA_W-1:0] sh_q, sh_d, tx_q, tx_d, addr_q, addr_d, wdata_q, wdata_d;
	logic                    sclk_q, rd_q, rd_d, rdreq_q, rdreq_d, wrreq_q, wrreq_d;
	logic                    load_q, txo_q, txo_d, oen_q, oen_d;
	logic                    rise, fall;

	assign rise = sif.sclk & ~sclk_q;
	assign fall = ~sif.sclk & sclk_q;

	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		tx_d    = load_q ? sif.rdata : tx_q;
		addr_d  = addr_q;
		wdata_d = wdata_q;
		rd_d    = rd_q;
		rdreq_d = 1'b0;
		wrreq_d = 1'b0;
		txo_d   = txo_q;
		oen_d   = oen_q;
		if (sif.cs_n) begin
			st_d  = SER_IDLE;
			cnt_d = `HBPI_CNT_RST;
			oen_d = 1'b1;
			txo_d = 1'b1;
		end else begin
			case (st_q)
				SER_IDLE: begin
					st_d  = SER_HDR;
					cnt_d = `HBPI_CNT_RST;
				end
				SER_HDR: begin
					oen_d = 1'b1;
					if (rise) begin
						sh_d  = {sh_q[6:0], sif.sdi};
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == `HBPI_BYTE_LAST) begin
							// header msb set means read
							rd_d    = sh_q[6];
							rdreq_d = sh_q[6];
							addr_d  = {1'b0, sh_q[5:0], sif.sdi};
							cnt_d   = `HBPI_CNT_RST;
							st_d    = SER_DATA;
						end
					end
				end
				SER_DATA: begin
					if (rise) begin
						sh_d  = {sh_q[6:0], sif.sdi};
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == `HBPI_BYTE_LAST) begin
							st_d = SER_IDLE;
							if (!rd_q) begin
								wdata_d = {sh_q[6:0], sif.sdi};
								wrreq_d = 1'b1;
							end
						end
					end
					if (fall && rd_q) begin
						// open drain only pulls low, never drives high
						txo_d = sif.od_mode ? 1'b0 : tx_q[7];
						oen_d = sif.od_mode ? tx_q[7] : 1'b0;
						tx_d  = {tx_q[6:0], 1'b1};
					end
				end
				default: st_d = SER_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q    <= SER_IDLE;
			cnt_q   <= `HBPI_CNT_RST;
			sh_q    <= `HBPI_BYTE_RST;
			tx_q    <= `HBPI_BYTE_RST;
			addr_q  <= `HBPI_BYTE_RST;
			wdata_q <= `HBPI_BYTE_RST;
			sclk_q  <= 1'b1;
			rd_q    <= 1'b0;
			rdreq_q <= 1'b0;
			wrreq_q <= 1'b0;
			load_q  <= 1'b0;
			txo_q   <= 1'b1;
			oen_q   <= 1'b1;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			tx_q    <= tx_d;
			addr_q  <= addr_d;
			wdata_q <= wdata_d;
			sclk_q  <= sif.sclk;
			rd_q    <= rd_d;
			rdreq_q <= rdreq_d;
			wrreq_q <= wrreq_d;
			load_q  <= rdreq_q;
			txo_q   <= txo_d;
			oen_q   <= oen_d;
		end
	end

	assign sif.serial_port_tx      = txo_q;
	assign sif.serial_port_tx_oe_n = oen_q;
	assign sif.rd_req   = rdreq_q;
	assign sif.wr_req   = wrreq_q;
	assign sif.addr     = addr_q;
	assign sif.wdata    = wdata_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	ser_hdr_read_a: assert property (rise && !sif.cs_n && st_q == SER_HDR && cnt_q == `HBPI_BYTE_LAST
		&& sh_q[6] |=> rdreq_q && st_q == SER_DATA)
		else $error("serial read header not taken");
	ser_od_low_a: assert property (sif.od_mode && !oen_q |-> !txo_q)
		else $error("open drain output drove high");
	ser_cs_idle_a: assert property (sif.cs_n |=> st_q == SER_IDLE && oen_q)
		else $error("serial engine active without select");
	ser_wr_only_a: assert property (wrreq_q |-> !rd_q && $past(st_q) == SER_DATA)
		else $error("serial write pulse out of place");
	ser_rd_cov: cover property (rdreq_q ##[1:300] fall && rd_q);
endmodule

//--- core/hbpi_top.sv
// host bus pin interface: parallel and serial register access port
`timescale 1ns/1ps
`include "hbpi_consts.svh"
module hbpi_top import hbpi_pkg::*; (
	input  wire logic                    SYS_CLK,                        // 200 MHz clock
	input  wire logic                    RESET,                          // async reset, high
	input  wire logic                    EXT_RESET_N,                    // strap sampling reset pin
	input  wire logic                    CS_N,                           // chip select
	input  wire logic                    RD_DATA_STROBE_N,               // read strobe or data_strobe_n
	input  wire logic                    WR_RW,                          // write strobe low or read/write
	input  wire logic                    ALE,                            // address latch strobe
	input  wire logic [`HBPI_SEP_W-1:0]  SEPARATE_ADDRESS_INPUTS,        // non-mux address
	input  wire logic [`HBPI_DATA_W-1:0] SHARED_ADDR_DATA_LINES_IN,      // pin levels
	output logic      [`HBPI_DATA_W-1:0] SHARED_ADDR_DATA_LINES_OUT,     // drive values
	output logic      [`HBPI_DATA_W-1:0] SHARED_ADDR_DATA_LINES_OE_N,    // low drives pin
	input  wire logic                    INDIRECT_MODE,                  // indirect addressing
	input  wire logic                    TX_OPEN_DRAIN,                  // serial tx open drain
	output logic      [`HBPI_DATA_W-1:0] REG_ADDR,                       // register address
	output logic      [`HBPI_DATA_W-1:0] REG_WDATA,                      // write data
	output logic                         REG_WR,                         // write pulse
	output logic                         REG_RD,                         // read pulse
	input  wire logic [`HBPI_DATA_W-1:0] REG_RDATA,                      // read data of REG_ADDR
	output logic      [1:0]              BUS_MODE,                       // strapped mode
	output logic                         MUX_MODE                        // strapped multiplexing
);
	hbpi_ser_if sif ();

	hbpi_mode_e              mode_q, mode_d;
	logic                    run_q, run_d, mux_q, mux_d, rstin_q;
	logic                    ale_q, strb_q, wr_q, cs_q, ract_q;
	logic                    rwr_q, rwr_d, rrd_q, rrd_d;
	logic [`HBPI_DATA_W-1:0] ad_q, lat_q, lat_d, ptr_q, ptr_d, raddr_q, raddr_d, wdata_q, wdata_d;
	logic [`HBPI_DATA_W-1:0] out_q, out_d, oe_q, oe_d;
	logic                    par, ser_on, rd_now, wr_end, ptr_sel;

	function automatic logic [`HBPI_DATA_W-1:0] acc_addr(
		input logic                    mux,
		input logic                    ind,
		input logic [`HBPI_DATA_W-1:0] lat,
		input logic [`HBPI_DATA_W-1:0] ptr,
		input logic [`HBPI_SEP_W-1:0]  sep);
		if (mux)
			acc_addr = lat;
		else if (ind)
			acc_addr = ptr;
		else
			acc_addr = {1'b0, sep};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// strap capture
	always_comb begin
		mode_d = mode_q;
		mux_d  = mux_q;
		run_d  = run_q;
		if (!EXT_RESET_N) begin
			run_d = 1'b0;
		end else if (!rstin_q) begin
			// levels present at the release edge decide the port until the next release
			run_d  = 1'b1;
			mux_d  = ALE;
			mode_d = (!WR_RW && !RD_DATA_STROBE_N) ? MODE_SERIAL : (!WR_RW ? MODE_DSTROBE : MODE_STROBES);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// parallel and serial access
	assign par     = run_q && (mode_q != MODE_SERIAL);
	assign ser_on  = run_q && (mode_q == MODE_SERIAL);
	assign ptr_sel = INDIRECT_MODE && !mux_q && !SEPARATE_ADDRESS_INPUTS[`HBPI_IND_SEL_BIT];
	assign rd_now  = par && !CS_N && !RD_DATA_STROBE_N && (mode_q == MODE_STROBES || WR_RW);
	assign wr_end  = par && !cs_q && !wr_q
		&& (mode_q == MODE_STROBES ? WR_RW : (!strb_q && RD_DATA_STROBE_N));

	assign sif.cs_n    = CS_N || !ser_on;
	assign sif.sclk    = SHARED_ADDR_DATA_LINES_IN[`HBPI_SCLK_BIT];
	assign sif.sdi     = SHARED_ADDR_DATA_LINES_IN[`HBPI_RX_BIT];
	assign sif.od_mode = TX_OPEN_DRAIN;
	assign sif.rdata   = REG_RDATA;

	always_comb begin
		lat_d   = lat_q;
		ptr_d   = ptr_q;
		raddr_d = raddr_q;
		wdata_d = wdata_q;
		rwr_d   = 1'b0;
		rrd_d   = 1'b0;
		out_d   = out_q;
		oe_d    = `HBPI_OE_OFF;
		if (par && mux_q && ale_q && !ALE)
			lat_d = SHARED_ADDR_DATA_LINES_IN;
		if (rd_now && !ract_q && !ptr_sel) begin
			rrd_d   = 1'b1;
			raddr_d = acc_addr(mux_q, INDIRECT_MODE, lat_q, ptr_q, SEPARATE_ADDRESS_INPUTS);
		end
		if (ract_q)
			out_d = ptr_sel ? ptr_q : REG_RDATA;
		if (rd_now)
			oe_d = `HBPI_OE_ON;
		if (wr_end) begin
			if (ptr_sel) begin
				ptr_d = ad_q;
			end else begin
				rwr_d   = 1'b1;
				raddr_d = acc_addr(mux_q, INDIRECT_MODE, lat_q, ptr_q, SEPARATE_ADDRESS_INPUTS);
				wdata_d = ad_q;
			end
		end
		if (ser_on) begin
			oe_d  = {sif.serial_port_tx_oe_n, `HBPI_SER_OE_LOW};
			out_d = {sif.serial_port_tx, `HBPI_SER_OUT_LOW};
			if (sif.rd_req) begin
				rrd_d   = 1'b1;
				raddr_d = sif.addr;
			end
			if (sif.wr_req) begin
				rwr_d   = 1'b1;
				raddr_d = sif.addr;
				wdata_d = sif.wdata;
			end
		end
	end

	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			mode_q  <= MODE_STROBES;
			mux_q   <= 1'b0;
			run_q   <= 1'b0;
			rstin_q <= 1'b0;
			ale_q   <= 1'b0;
			strb_q  <= 1'b1;
			wr_q    <= 1'b1;
			cs_q    <= 1'b1;
			ract_q  <= 1'b0;
			ad_q    <= `HBPI_BYTE_RST;
			lat_q   <= `HBPI_BYTE_RST;
			ptr_q   <= `HBPI_BYTE_RST;
			raddr_q <= `HBPI_BYTE_RST;
			wdata_q <= `HBPI_BYTE_RST;
			rwr_q   <= 1'b0;
			rrd_q   <= 1'b0;
			out_q   <= `HBPI_BYTE_RST;
			oe_q    <= `HBPI_OE_OFF;
		end else begin
			mode_q  <= mode_d;
			mux_q   <= mux_d;
			run_q   <= run_d;
			rstin_q <= EXT_RESET_N;
			ale_q   <= ALE;
			strb_q  <= RD_DATA_STROBE_N;
			wr_q    <= WR_RW;
			cs_q    <= CS_N;
			ract_q  <= rd_now;
			ad_q    <= SHARED_ADDR_DATA_LINES_IN;
			lat_q   <= lat_d;
			ptr_q   <= ptr_d;
			raddr_q <= raddr_d;
			wdata_q <= wdata_d;
			rwr_q   <= rwr_d;
			rrd_q   <= rrd_d;
			out_q   <= out_d;
			oe_q    <= oe_d;
		end
	end

	hbpi_serial u_serial (
		.clk (SYS_CLK),
		.rst (RESET),
		.sif (sif.engine)
	);

	assign SHARED_ADDR_DATA_LINES_OUT  = out_q;
	assign SHARED_ADDR_DATA_LINES_OE_N = oe_q;
	assign REG_ADDR                    = raddr_q;
	assign REG_WDATA                   = wdata_q;
	assign REG_WR                      = rwr_q;
	assign REG_RD                      = rrd_q;
	assign BUS_MODE                    = mode_q;
	assign MUX_MODE                    = mux_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);

	cs_gates_strobes_a: assert property (par && CS_N && $past(CS_N) |=> !REG_WR && !REG_RD)
		else $error("access taken without chip select");
	lines_released_a: assert property (par && CS_N |=> SHARED_ADDR_DATA_LINES_OE_N == `HBPI_OE_OFF)
		else $error("shared lines driven outside a read");
	mux_addr_latch_a: assert property (par && mux_q && $fell(ALE)
		|=> lat_q == $past(SHARED_ADDR_DATA_LINES_IN))
		else $error("multiplexed address not latched");
	nonmux_address_a: assert property (!mux_q && !INDIRECT_MODE && wr_end
		|=> REG_WR && REG_ADDR == {1'b0, $past(SEPARATE_ADDRESS_INPUTS)})
		else $error("separate address not used");
	mux_ignores_sep_a: assert property (mux_q && wr_end |=> REG_WR && REG_ADDR == $past(lat_q))
		else $error("multiplexed write used wrong address");
	indirect_decode_a: assert property (!mux_q && INDIRECT_MODE && wr_end && SEPARATE_ADDRESS_INPUTS[0]
		|=> REG_WR && REG_ADDR == $past(ptr_q))
		else $error("indirect access used wrong address");
	strobe_write_end_a: assert property (par && mode_q == MODE_DSTROBE && !INDIRECT_MODE
		&& $rose(RD_DATA_STROBE_N) && !$past(WR_RW) && !$past(CS_N) |=> REG_WR && REG_WDATA == $past(ad_q))
		else $error("data strobe write not completed");
	// a read start must both drive the lines and raise one read pulse
	read_drive_a: assert property (par && mode_q == MODE_STROBES && !CS_N && !RD_DATA_STROBE_N && !ptr_sel
		|=> SHARED_ADDR_DATA_LINES_OE_N == `HBPI_OE_ON && (REG_RD || $past(ract_q)))
		else $error("read strobe did not drive data");
	dir_write_release_a: assert property (par && mode_q == MODE_DSTROBE && !WR_RW
		|=> SHARED_ADDR_DATA_LINES_OE_N == `HBPI_OE_OFF)
		else $error("write direction drove the lines");
	serial_pins_a: assert property (ser_on |=> SHARED_ADDR_DATA_LINES_OE_N[6:0] == `HBPI_SER_OE_LOW)
		else $error("serial input pins driven");
	strap_capture_a: assert property ($rose(EXT_RESET_N) |=> MUX_MODE == $past(ALE) && run_q)
		else $error("straps not captured at release");

	par_read_cov: cover property (REG_RD && par ##1 SHARED_ADDR_DATA_LINES_OE_N == `HBPI_OE_ON);
	strobe_write_cov: cover property (REG_WR && mode_q == MODE_DSTROBE);
	mux_write_cov: cover property (REG_WR && mux_q);
	serial_cov: cover property (REG_WR && ser_on);
endmodule

//--- test/hbpi_host_model.sv
// host microcontroller model driving the parallel and serial port pins
`timescale 1ns/1ps
module hbpi_host_model import hbpi_pkg::*; (
	input  wire logic       clk,      // bench clock
	input  wire logic [7:0] pin,      // resolved shared line levels
	output logic            cs_n,     // chip select
	output logic            rd_stb_n, // read or data strobe
	output logic            wr_rw,    // write strobe or direction
	output logic            ale,      // address latch strobe
	output logic [6:0]      sep_addr, // separate address inputs
	output logic [7:0]      drv,      // shared line drive values
	output logic [7:0]      drv_oe    // high where host drives
);
	initial begin
		cs_n = 1'b1;
		rd_stb_n = 1'b1;
		wr_rw = 1'b1;
		ale = 1'b0;
		sep_addr = 7'h00;
		drv = 8'h00;
		drv_oe = 8'h00;
	end

	task automatic levels(input hbpi_mode_e bm, input bit mux, input bit strap);
		cs_n = 1'b1;
		drv_oe = 8'h00;
		ale = mux;
		wr_rw = strap ? (bm == MODE_STROBES) : 1'b1;
		rd_stb_n = strap ? (bm != MODE_SERIAL) : 1'b1;
	endtask

	task automatic addr_ph(input bit mux, input bit sel, input logic [7:0] a);
		@(negedge clk);
		cs_n = ~sel;
		if (mux) begin
			// junk on the unused inputs so a wrong source shows
			sep_addr = ~a[6:0];
			drv = a;
			drv_oe = 8'hFF;
			@(negedge clk);
			ale = 1'b0;
			@(negedge clk);
		end else begin
			sep_addr = a[6:0];
		end
	endtask

	task automatic pwr(input hbpi_mode_e bm, input bit mux, input bit sel, input logic [7:0] a, d);
		addr_ph(mux, sel, a);
		drv = d;
		drv_oe = 8'hFF;
		wr_rw = 1'b0;
		if (bm == MODE_DSTROBE) begin
			rd_stb_n = 1'b0;
		end
		repeat (2) @(negedge clk);
		if (bm == MODE_STROBES) begin
			wr_rw = 1'b1;
		end else begin
			rd_stb_n = 1'b1;
		end
		@(negedge clk);
		levels(bm, mux, 1'b0);
	endtask

	task automatic prd(input hbpi_mode_e bm, input bit mux, input logic [7:0] a, output logic [7:0] q);
		addr_ph(mux, 1'b1, a);
		drv_oe = 8'h00;
		wr_rw = 1'b1;
		rd_stb_n = 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		q = pin;
		levels(bm, mux, 1'b0);
	endtask

	task automatic ser(input logic [7:0] hdr, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		cs_n = 1'b0;
		drv = 8'h00;
		drv_oe = 8'h60;
		repeat (2) @(negedge clk);
		for (int i = 0; i < 16; i++) begin
			drv[5] = 1'b0;
			drv[6] = (i < 8) ? hdr[7 - i] : d[15 - i];
			repeat (4) @(negedge clk);
			if (i >= 8) begin
				q[15 - i] = pin[7];
			end
			drv[5] = 1'b1;
			repeat (4) @(negedge clk);
		end
		drv[5] = 1'b0;
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		drv_oe = 8'h00;
	endtask
endmodule

//--- test/hbpi_top_bench.sv
// self-checking bench of the host bus pin interface
`timescale 1ns/1ps
module hbpi_top_bench import hbpi_pkg::*;;
	logic       sys_clk = 1'b0;
	logic       reset, ext_reset_n, ind_mode, tx_od, reg_wr, reg_rd, mux_mode;
	logic       cs_n, rd_stb_n, wr_rw, ale;
	logic [6:0] sep;
	logic [7:0] drv, drv_oe, ad_out, ad_oe_n, reg_addr, reg_wdata, reg_rdata;
	logic [7:0] wa, wd, ra, a, d, q, ptr;
	logic [1:0] bus_mode;
	wire  [7:0] pin;
	hbpi_mode_e bm;
	bit         mux;
	int         n_mismatch, check_count, n_wr, n_rd, seed, w0, r0;

	// pull-ups hold released lines high
	assign pin = (~ad_oe_n & ad_out) | (ad_oe_n & drv_oe & drv) | (ad_oe_n & ~drv_oe);

	function automatic logic [7:0] reg_val(input logic [7:0] x);
		return {x[3:0], ~x[7:4]} ^ 8'hA5;
	endfunction
	assign reg_rdata = reg_val(reg_addr);

	always #2.5 sys_clk = ~sys_clk;

	hbpi_top u_hbpi_top (.SYS_CLK(sys_clk), .RESET(reset), .EXT_RESET_N(ext_reset_n), .CS_N(cs_n),
		.RD_DATA_STROBE_N(rd_stb_n), .WR_RW(wr_rw), .ALE(ale), .SEPARATE_ADDRESS_INPUTS(sep),
		.SHARED_ADDR_DATA_LINES_IN(pin), .SHARED_ADDR_DATA_LINES_OUT(ad_out),
		.SHARED_ADDR_DATA_LINES_OE_N(ad_oe_n), .INDIRECT_MODE(ind_mode), .TX_OPEN_DRAIN(tx_od),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .BUS_MODE(bus_mode), .MUX_MODE(mux_mode));
	hbpi_host_model u_hbpi_host_model (.clk(sys_clk), .pin(pin), .cs_n(cs_n), .rd_stb_n(rd_stb_n),
		.wr_rw(wr_rw), .ale(ale), .sep_addr(sep), .drv(drv), .drv_oe(drv_oe));

	always @(posedge sys_clk) begin
		if (reg_wr === 1'b1) begin
			n_wr++;
			wa = reg_addr;
			wd = reg_wdata;
		end
		if (reg_rd === 1'b1) begin
			n_rd++;
			ra = reg_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic strap(input hbpi_mode_e m, input bit x);
		@(negedge sys_clk);
		ext_reset_n = 1'b0;
		u_hbpi_host_model.levels(m, x, 1'b1);
		repeat (3) @(negedge sys_clk);
		ext_reset_n = 1'b1;
		repeat (2) @(negedge sys_clk);
		check({6'h00, bus_mode}, {6'h00, m});
		check({7'h00, mux_mode}, {7'h00, x});
		u_hbpi_host_model.levels(m, x, 1'b0);
	endtask

	task automatic par_pair(input logic [7:0] ad, dd);
		logic [7:0] ea;
		ea = mux ? ad : {1'b0, ad[6:0]};
		w0 = n_wr;
		r0 = n_rd;
		u_hbpi_host_model.pwr(bm, mux, 1'b1, ad, dd);
		repeat (2) @(negedge sys_clk);
		check(8'(n_wr - w0), 8'h01);
		check(wa, ea);
		check(wd, dd);
		u_hbpi_host_model.prd(bm, mux, ad, q);
		repeat (2) @(negedge sys_clk);
		check(8'(n_rd - r0), 8'h01);
		check(ra, ea);
		check(q, reg_val(ea));
		check(ad_oe_n, 8'hFF);
		u_hbpi_host_model.pwr(bm, mux, 1'b0, ~ad, ~dd);
		repeat (2) @(negedge sys_clk);
		check(8'(n_wr - w0), 8'h01);
	endtask

	////////////////////////////////////////////////////////////////////////////////

	initial begin
		repeat (50000) @(posedge sys_clk);
		n_mismatch++;
		stop_test();
	end

	initial begin
		seed = 95282;
		reset = 1'b1;
		ext_reset_n = 1'b0;
		ind_mode = 1'b0;
		tx_od = 1'b0;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 1'b0;
		check(ad_oe_n, 8'hFF);
		for (int m = 0; m < 4; m++) begin
			bm = m[1] ? MODE_DSTROBE : MODE_STROBES;
			mux = m[0];
			strap(bm, mux);
			for (int k = 0; k < 6; k++) begin
				a = (k == 0) ? 8'hFF : 8'($random(seed));
				d = (k == 1) ? 8'h00 : 8'($random(seed));
				par_pair(a, d);
			end
		end
		// indirect pointer in non-multiplexed separate-strobe mode
		bm = MODE_STROBES;
		mux = 1'b0;
		strap(bm, mux);
		ind_mode = 1'b1;
		a = 8'($random(seed)) & 8'hFE;
		ptr = 8'($random(seed));
		d = 8'($random(seed));
		w0 = n_wr;
		u_hbpi_host_model.pwr(bm, mux, 1'b1, a, ptr);
		repeat (2) @(negedge sys_clk);
		check(8'(n_wr - w0), 8'h00);
		u_hbpi_host_model.prd(bm, mux, a, q);
		check(q, ptr);
		u_hbpi_host_model.pwr(bm, mux, 1'b1, ~a, d);
		repeat (2) @(negedge sys_clk);
		check(wa, ptr);
		check(wd, d);
		u_hbpi_host_model.prd(bm, mux, ~a, q);
		check(q, reg_val(ptr));
		ind_mode = 1'b0;
		// serial port, push-pull and open-drain transmit
		strap(MODE_SERIAL, 1'b0);
		for (int k = 0; k < 4; k++) begin
			@(negedge sys_clk);
			tx_od = k[0];
			a = (k == 0) ? 8'h7F : 8'($random(seed)) & 8'h7F;
			d = 8'($random(seed));
			w0 = n_wr;
			u_hbpi_host_model.ser(a, d, q);
			repeat (2) @(negedge sys_clk);
			check(8'(n_wr - w0), 8'h01);
			check(wa, a);
			check(wd, d);
			u_hbpi_host_model.ser(a | 8'h80, 8'h00, q);
			repeat (2) @(negedge sys_clk);
			check(q, reg_val(a));
			check(ra, a);
			check(ad_oe_n, 8'hFF);
		end
		stop_test();
	end
endmodule
